// File: lpmc_pkg.sv
package lpmc_pkg;
	localparam logic [2:0] LPMC_SEL_CLOCK_STOP = 3'h1;
	localparam logic [2:0] LPMC_SEL_IDLE = 3'h3;
	localparam logic [2:0] LPMC_SEL_POWER_GATED = 3'h5;
	localparam logic [2:0] LPMC_SEL_RESET = 3'h0;

	localparam logic [3:0] LPMC_ADDR_STANDBY_CTRL = 4'h0;
	localparam logic [3:0] LPMC_ADDR_STATUS = 4'h4;
	localparam logic [3:0] LPMC_ADDR_RESET_CAUSE = 4'h8;
	localparam logic [3:0] LPMC_ADDR_WARMUP = 4'hc;

	localparam int LPMC_SEL_LSB = 0;
	localparam int LPMC_HOLD_BIT = 8;

	localparam int LPMC_CLK_MHZ = 250;
	localparam int LPMC_GATE_MIN_NS = 45000;
	localparam int LPMC_GATE_MIN_CYC = (LPMC_GATE_MIN_NS * LPMC_CLK_MHZ + 999) / 1000;
	localparam logic [15:0] LPMC_WARMUP_RESET = 16'h0300;

	localparam logic [7:0] LPMC_CAUSE_PIN = 8'h01;
	localparam logic [7:0] LPMC_CAUSE_UNDERVOLT = 8'h02;
	localparam logic [7:0] LPMC_CAUSE_WATCHDOG = 8'h04;
	localparam logic [7:0] LPMC_CAUSE_GATED_WAKE = 8'h08;

	typedef enum logic [6:0] {
		LPMC_ST_NORMAL = 7'h01,
		LPMC_ST_ENTER = 7'h02,
		LPMC_ST_IDLE = 7'h04,
		LPMC_ST_CLK_STOP = 7'h08,
		LPMC_ST_PWR_GATED = 7'h10,
		LPMC_ST_WARMUP = 7'h20,
		LPMC_ST_RESTORE = 7'h40
	} lpmc_state_t;

	typedef struct packed {
		logic periph_irq;
		logic tick_irq;
		logic watchdog_nmi;
		logic undervoltage_nmi;
		logic wake_pin_irq;
		logic calendar_wake_irq;
		logic watchdog_rst;
		logic undervoltage_rst;
	} lpmc_wake_t;

	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic fast_osc_en;
		logic main_supply_en;
		logic port_hold;
		logic sys_clk_en;
		logic core_reset_req;
	} lpmc_ctrl_t;
endpackage : lpmc_pkg

// File: lpmc_counter.sv
`timescale 1ns/1ps
module lpmc_counter import lpmc_pkg::*; #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic load_i,
	input wire logic [WIDTH-1:0] value_i,
	// Status
	output logic done_o
);
	initial begin
		if (WIDTH < 2) $error("lpmc_counter: WIDTH too small");
	end

	logic [WIDTH-1:0] count;
	wire logic at_zero = (count == '0);
	wire logic [WIDTH-1:0] next_count = load_i ? value_i : (at_zero ? count : count - 1'b1);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign done_o = at_zero & ~load_i;
endmodule : lpmc_counter

// File: lpmc_controller.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module lpmc_controller import lpmc_pkg::*; #(
	parameter int WARMUP_WIDTH = 16,
	parameter int GATE_MIN_CYC = LPMC_GATE_MIN_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Processor core
	input wire logic wait_for_interrupt_instr_i,
	input wire logic wait_for_event_instr_i,
	// Release sources
	input wire lpmc_wake_t wake_i,
	// Port pins to hold
	input wire logic [31:0] port_state_i,
	output logic [31:0] port_state_o,
	// Clock and supply control
	output lpmc_ctrl_t ctrl_o,
	output lpmc_state_t state_o
);
	initial begin
		if (WARMUP_WIDTH < 2 || WARMUP_WIDTH > 16) $error("lpmc_controller: WARMUP_WIDTH out of range");
		if (GATE_MIN_CYC < 1 || GATE_MIN_CYC >= (1 << 16)) $error("lpmc_controller: GATE_MIN_CYC out of range");
	end

	lpmc_state_t state;
	lpmc_state_t next_state;
	logic [2:0] low_power_select;
	logic port_state_hold;
	logic [7:0] reset_cause_flags;
	logic [WARMUP_WIDTH-1:0] warmup_value;
	logic [15:0] gate_count;
	logic wfi_q;
	logic [31:0] held_ports;
	logic [31:0] rdata;
	logic gated_wake_flag;

	// Register decode
	wire logic wr_ctrl = reg_wr_i & (reg_addr_i == LPMC_ADDR_STANDBY_CTRL);
	wire logic wr_cause = reg_wr_i & (reg_addr_i == LPMC_ADDR_RESET_CAUSE);
	wire logic wr_warmup = reg_wr_i & (reg_addr_i == LPMC_ADDR_WARMUP);

	// Release source grouping
	wire logic idle_release = wake_i.periph_irq | wake_i.tick_irq | wake_i.watchdog_nmi
		| wake_i.undervoltage_nmi | wake_i.wake_pin_irq | wake_i.calendar_wake_irq
		| wake_i.watchdog_rst | wake_i.undervoltage_rst;
	// Watchdog, tick and peripheral sources deliberately left out
	wire logic stop_release_irq = wake_i.wake_pin_irq | wake_i.calendar_wake_irq;
	wire logic stop_release_rst = wake_i.undervoltage_rst;
	wire logic stop_release = stop_release_irq | stop_release_rst;

	wire logic sel_idle = (low_power_select == LPMC_SEL_IDLE);
	wire logic sel_clk_stop = (low_power_select == LPMC_SEL_CLOCK_STOP);
	wire logic sel_gated = (low_power_select == LPMC_SEL_POWER_GATED);
	wire logic sel_valid = sel_idle | sel_clk_stop | sel_gated;
	wire logic entry_release = sel_idle ? idle_release : stop_release;

	// Synchronous sample; only the rising edge of the wait indication starts entry
	wire logic wfi_rise = wait_for_interrupt_instr_i & ~wfi_q;
	wire logic warmup_done;
	wire logic warmup_load = (state == LPMC_ST_CLK_STOP || state == LPMC_ST_PWR_GATED) & stop_release_irq;
	wire logic gate_min_met = (gate_count == 16'h0000);

	lpmc_counter #(
		.WIDTH(WARMUP_WIDTH)
	) u_warmup (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.load_i(warmup_load),
		.value_i(warmup_value),
		.done_o(warmup_done)
	);

	always_comb begin
		next_state = state;
		case (state)
			LPMC_ST_NORMAL: begin
				// Wait-for-event is ignored: there is no event source
				if (wfi_rise & sel_valid) begin
					next_state = LPMC_ST_ENTER;
				end
			end
			LPMC_ST_ENTER: begin
				if (entry_release) begin
					next_state = LPMC_ST_NORMAL;
				end else if (sel_idle) begin
					next_state = LPMC_ST_IDLE;
				end else if (sel_clk_stop) begin
					next_state = LPMC_ST_CLK_STOP;
				end else if (sel_gated) begin
					next_state = LPMC_ST_PWR_GATED;
				end else begin
					next_state = LPMC_ST_NORMAL;
				end
			end
			LPMC_ST_IDLE: begin
				if (idle_release) begin
					next_state = LPMC_ST_NORMAL;
				end
			end
			LPMC_ST_CLK_STOP: begin
				if (stop_release_rst) begin
					next_state = LPMC_ST_NORMAL;
				end else if (stop_release_irq) begin
					next_state = LPMC_ST_WARMUP;
				end
			end
			LPMC_ST_PWR_GATED: begin
				// Early release would upset supply management: hold off until minimum time
				if (gate_min_met & stop_release_rst) begin
					next_state = LPMC_ST_NORMAL;
				end else if (gate_min_met & stop_release_irq) begin
					next_state = LPMC_ST_WARMUP;
				end
			end
			LPMC_ST_WARMUP: begin
				if (warmup_done) begin
					next_state = gated_wake_flag ? LPMC_ST_RESTORE : LPMC_ST_NORMAL;
				end
			end
			LPMC_ST_RESTORE: begin
				next_state = LPMC_ST_NORMAL;
			end
			default: begin
				next_state = LPMC_ST_NORMAL;
			end
		endcase
	end

	// State and capture of the wait edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= LPMC_ST_NORMAL;
			wfi_q <= 1'b0;
		end else begin
			state <= next_state;
			wfi_q <= wait_for_interrupt_instr_i;
		end
	end

	// Minimum stay in gated stop
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate_count <= 16'h0000;
		end else if (next_state == LPMC_ST_PWR_GATED && state != LPMC_ST_PWR_GATED) begin
			gate_count <= 16'(GATE_MIN_CYC - 1);
		end else if (!gate_min_met) begin
			gate_count <= gate_count - 16'h0001;
		end
	end

	// Gated-stop wake marker, cleared once the restore step runs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gated_wake_flag <= 1'b0;
		end else if (state == LPMC_ST_PWR_GATED && next_state == LPMC_ST_WARMUP) begin
			gated_wake_flag <= 1'b1;
		end else if (state == LPMC_ST_RESTORE) begin
			gated_wake_flag <= 1'b0;
		end
	end

	// Software-visible control
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			low_power_select <= LPMC_SEL_RESET;
			port_state_hold <= 1'b0;
			warmup_value <= WARMUP_WIDTH'(LPMC_WARMUP_RESET);
		end else begin
			if (wr_ctrl) begin
				low_power_select <= reg_wdata_i[LPMC_SEL_LSB +: 3];
				port_state_hold <= reg_wdata_i[LPMC_HOLD_BIT];
			end
			if (wr_warmup) begin
				warmup_value <= reg_wdata_i[WARMUP_WIDTH-1:0];
			end
		end
	end

	// Cause flags: hardware set wins over a software clear in the same cycle
	wire logic [7:0] cause_set = ((state == LPMC_ST_RESTORE) ? LPMC_CAUSE_GATED_WAKE : 8'h00)
		| ((state != LPMC_ST_NORMAL && wake_i.undervoltage_rst) ? LPMC_CAUSE_UNDERVOLT : 8'h00)
		| ((state == LPMC_ST_IDLE && wake_i.watchdog_rst) ? LPMC_CAUSE_WATCHDOG : 8'h00);
	wire logic [7:0] cause_clr = wr_cause ? reg_wdata_i[7:0] : 8'h00;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reset_cause_flags <= LPMC_CAUSE_PIN;
		end else begin
			reset_cause_flags <= (reset_cause_flags & ~cause_clr) | cause_set;
		end
	end

	// Port latch follows pins until hold is set and the gated stop, warm-up or restore state runs
	wire logic ports_frozen = port_state_hold & (state == LPMC_ST_PWR_GATED || state == LPMC_ST_WARMUP
		|| state == LPMC_ST_RESTORE);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			held_ports <= 32'h0000_0000;
		end else if (!ports_frozen) begin
			held_ports <= port_state_i;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads return zero
	wire logic [31:0] rd_mux =
		(reg_addr_i == LPMC_ADDR_STANDBY_CTRL) ? {23'h0, port_state_hold, 5'h0, low_power_select} :
		(reg_addr_i == LPMC_ADDR_STATUS) ? {25'h0, state} :
		(reg_addr_i == LPMC_ADDR_RESET_CAUSE) ? {24'h0, reset_cause_flags} :
		(reg_addr_i == LPMC_ADDR_WARMUP) ? {{(32 - WARMUP_WIDTH){1'b0}}, warmup_value} : 32'h0000_0000;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			rdata <= rd_mux;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// Clock and supply outputs per mode
	wire logic in_clk_stop = (state == LPMC_ST_CLK_STOP);
	wire logic in_gated = (state == LPMC_ST_PWR_GATED);
	wire logic in_warmup = (state == LPMC_ST_WARMUP);

	// Idle gates only the core; peripherals apply their own idle-enable bits
	assign ctrl_o.core_clk_en = (state == LPMC_ST_NORMAL || state == LPMC_ST_ENTER);
	assign ctrl_o.periph_clk_en = ~(in_clk_stop | in_gated | in_warmup);
	assign ctrl_o.fast_osc_en = ~(in_clk_stop | in_gated);
	assign ctrl_o.main_supply_en = ~in_gated;
	assign ctrl_o.port_hold = ports_frozen;
	assign ctrl_o.sys_clk_en = ~(in_clk_stop | in_gated | in_warmup);
	// Reset pulse reinitialises cut domains only; backup domain is not wired to it
	assign ctrl_o.core_reset_req = (state == LPMC_ST_RESTORE);

	assign port_state_o = held_ports;
	assign reg_rdata_o = rdata;
	assign state_o = state;
endmodule : lpmc_controller

// File: lpmc_core_model.sv
`timescale 1ns/1ps
module lpmc_core_model import lpmc_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Toward the controller
	output logic sleep_o,
	output logic event_o,
	output lpmc_wake_t wake_o,
	output logic [31:0] pins_o
);
	initial begin
		sleep_o = 1'b0;
		event_o = 1'b0;
		wake_o = '0;
		pins_o = 32'h0;
	end
	// Pins move every cycle so that a missing hold shows up at once
	always @(posedge clk_i) pins_o <= pins_o + 32'h1;
	task automatic sleep(input logic v);
		@(posedge clk_i);
		sleep_o <= v;
	endtask : sleep
	// Only used to show that an event never starts entry
	task automatic signal_event(input logic v);
		@(posedge clk_i);
		event_o <= v;
	endtask : signal_event
	// A level stays up until the bench has seen handling begin
	task automatic wake(input lpmc_wake_t w);
		@(posedge clk_i);
		wake_o <= w;
	endtask : wake
endmodule : lpmc_core_model

// File: lpmc_controller_chk.sv
`timescale 1ns/1ps
module lpmc_controller_chk import lpmc_pkg::*; #(
	parameter int WARMUP_WIDTH = 16,
	parameter int GATE_MIN_CYC = LPMC_GATE_MIN_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Core and sources
	input wire logic wait_for_interrupt_instr_i,
	input wire lpmc_wake_t wake_i,
	// Outputs watched
	input wire logic [31:0] port_state_o,
	input wire lpmc_ctrl_t ctrl_o,
	input wire lpmc_state_t state_o
);
	int gated_cyc;
	wire stop_wake = wake_i.wake_pin_irq | wake_i.calendar_wake_irq | wake_i.undervoltage_rst;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gated_cyc <= 0;
		end else begin
			gated_cyc <= (state_o == LPMC_ST_PWR_GATED) ? gated_cyc + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_enter;
		state_o == LPMC_ST_ENTER |-> $past(state_o) == LPMC_ST_NORMAL && $past(wait_for_interrupt_instr_i)
			&& !$past(wait_for_interrupt_instr_i, 2);
	endproperty
	a_enter: assert property (p_enter) else $error("entry without a new wait");
	property p_normal;
		state_o == LPMC_ST_NORMAL |-> ctrl_o.core_clk_en && ctrl_o.sys_clk_en && ctrl_o.fast_osc_en;
	endproperty
	a_normal: assert property (p_normal) else $error("normal mode not clocked");
	property p_idle;
		state_o == LPMC_ST_IDLE |-> !ctrl_o.core_clk_en && ctrl_o.periph_clk_en;
	endproperty
	a_idle: assert property (p_idle) else $error("idle clocks wrong");
	property p_clk_stop;
		state_o == LPMC_ST_CLK_STOP |-> !ctrl_o.periph_clk_en && !ctrl_o.fast_osc_en && ctrl_o.main_supply_en;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock stop gating wrong");
	property p_gated;
		state_o == LPMC_ST_PWR_GATED |-> !ctrl_o.main_supply_en && !ctrl_o.core_clk_en;
	endproperty
	a_gated: assert property (p_gated) else $error("supply not removed");
	property p_idle_wake;
		state_o == LPMC_ST_IDLE && wake_i != '0 |=> state_o == LPMC_ST_NORMAL;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle not released");
	property p_stop_hold;
		state_o == LPMC_ST_CLK_STOP && !stop_wake |=> state_o == LPMC_ST_CLK_STOP;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("clock stop left on a foreign source");
	property p_gate_min;
		state_o == LPMC_ST_PWR_GATED && gated_cyc < GATE_MIN_CYC - 1 |=> state_o == LPMC_ST_PWR_GATED;
	endproperty
	a_gate_min: assert property (p_gate_min) else $error("gated stop left too early");
	property p_stop_warm;
		state_o == LPMC_ST_CLK_STOP && !wake_i.undervoltage_rst && stop_wake |=> state_o == LPMC_ST_WARMUP
			##0 (!ctrl_o.sys_clk_en && ctrl_o.fast_osc_en);
	endproperty
	a_stop_warm: assert property (p_stop_warm) else $error("no warm-up before clock");
	property p_uv_exit;
		state_o == LPMC_ST_CLK_STOP && wake_i.undervoltage_rst |=> state_o == LPMC_ST_NORMAL;
	endproperty
	a_uv_exit: assert property (p_uv_exit) else $error("reset release warmed up");
	property p_restore;
		state_o == LPMC_ST_RESTORE |-> ctrl_o.core_reset_req && ctrl_o.main_supply_en ##1 state_o == LPMC_ST_NORMAL;
	endproperty
	a_restore: assert property (p_restore) else $error("gated exit without reset");
	property p_hold;
		ctrl_o.port_hold && $past(ctrl_o.port_hold) |-> $stable(port_state_o);
	endproperty
	a_hold: assert property (p_hold) else $error("held pins moved");
	c_idle: cover property (state_o == LPMC_ST_IDLE);
	c_stop: cover property (state_o == LPMC_ST_WARMUP);
	c_gated: cover property (state_o == LPMC_ST_RESTORE);
endmodule : lpmc_controller_chk

bind lpmc_controller lpmc_controller_chk #(.WARMUP_WIDTH(WARMUP_WIDTH), .GATE_MIN_CYC(GATE_MIN_CYC)) u_chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .wait_for_interrupt_instr_i(wait_for_interrupt_instr_i), .wake_i(wake_i),
	.port_state_o(port_state_o), .ctrl_o(ctrl_o), .state_o(state_o));

// File: low_power_mode_controller_test.sv
`timescale 1ns/1ps
module low_power_mode_controller_test import lpmc_pkg::*; ;
	logic clk, rst_b, wr, rd, sleep, evt;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, pins, port_o, snap;
	lpmc_wake_t wake;
	lpmc_ctrl_t ctrl;
	lpmc_state_t state;
	int err_count = 0;
	int checks_done = 0;
	lpmc_core_model core (.clk_i(clk), .sleep_o(sleep), .event_o(evt), .wake_o(wake), .pins_o(pins));
	lpmc_controller #(.GATE_MIN_CYC(4)) dut (.clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .wait_for_interrupt_instr_i(sleep),
		.wait_for_event_instr_i(evt), .wake_i(wake), .port_state_i(pins), .port_state_o(port_o), .ctrl_o(ctrl),
		.state_o(state));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : reg_chk
	task automatic wait_st(input lpmc_state_t s, input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (state === s) return;
		end
		chk(32'(state), 32'(s));
		print_verdict();
	endtask : wait_st
	task automatic t_reset();
		chk(32'(state), 32'(LPMC_ST_NORMAL));
		chk(32'(ctrl), 32'h7a);
		reg_chk(LPMC_ADDR_STANDBY_CTRL, 32'h0);
		reg_chk(LPMC_ADDR_RESET_CAUSE, 32'h1);
		reg_chk(LPMC_ADDR_WARMUP, 32'h300);
		reg_chk(4'h2, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_idle();
		for (int i = 0; i < 8; i++) begin
			reg_wr(LPMC_ADDR_STANDBY_CTRL, 32'h3);
			core.sleep(1'b1);
			wait_st(LPMC_ST_IDLE, 4);
			core.wake(8'h01 << i);
			wait_st(LPMC_ST_NORMAL, 3);
			core.wake(8'h00);
			core.sleep(1'b0);
		end
		reg_chk(LPMC_ADDR_RESET_CAUSE, 32'h7);
		$display("idle test done");
	endtask : t_idle
	task automatic t_bad();
		logic [2:0] sel [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
		foreach (sel[i]) begin
			reg_wr(LPMC_ADDR_STANDBY_CTRL, 32'(sel[i]));
			core.sleep(1'b1);
			repeat (4) @(posedge clk);
			#1;
			chk(32'(state), 32'(LPMC_ST_NORMAL));
			core.sleep(1'b0);
		end
		reg_wr(LPMC_ADDR_STANDBY_CTRL, 32'h3);
		core.signal_event(1'b1);
		repeat (4) @(posedge clk);
		#1;
		chk(32'(state), 32'(LPMC_ST_NORMAL));
		core.signal_event(1'b0);
		$display("bad select test done");
	endtask : t_bad
	task automatic t_stop(input lpmc_wake_t w, input lpmc_state_t nxt);
		reg_wr(LPMC_ADDR_WARMUP, 32'h3);
		reg_wr(LPMC_ADDR_STANDBY_CTRL, 32'h1);
		core.sleep(1'b1);
		wait_st(LPMC_ST_CLK_STOP, 4);
		core.wake(8'hf2);
		repeat (5) @(posedge clk);
		#1;
		chk(32'(state), 32'(LPMC_ST_CLK_STOP));
		core.wake(w);
		wait_st(nxt, 3);
		wait_st(LPMC_ST_NORMAL, 10);
		core.wake(8'h00);
		core.sleep(1'b0);
		$display("clock stop test done");
	endtask : t_stop
	task automatic t_gated();
		core.wake(8'h04);
		reg_wr(LPMC_ADDR_STANDBY_CTRL, 32'h105);
		core.sleep(1'b1);
		repeat (4) @(posedge clk);
		#1;
		chk(32'(state), 32'(LPMC_ST_NORMAL));
		core.sleep(1'b0);
		core.wake(8'h00);
		core.sleep(1'b1);
		wait_st(LPMC_ST_PWR_GATED, 4);
		snap = port_o;
		core.wake(8'h04);
		wait_st(LPMC_ST_WARMUP, 8);
		chk(port_o, snap);
		wait_st(LPMC_ST_RESTORE, 8);
		chk(32'(ctrl.core_reset_req), 32'h1);
		wait_st(LPMC_ST_NORMAL, 2);
		core.wake(8'h00);
		core.sleep(1'b0);
		reg_chk(LPMC_ADDR_RESET_CAUSE, 32'h8);
		$display("gated stop test done");
	endtask : t_gated
	task automatic t_pin_rst();
		reg_wr(LPMC_ADDR_STANDBY_CTRL, 32'h1);
		core.sleep(1'b1);
		wait_st(LPMC_ST_CLK_STOP, 4);
		@(posedge clk);
		rst_b <= 1'b0;
		// Wait is dropped before release; the select resets to 0, so no fresh entry would follow anyway
		core.sleep(1'b0);
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		chk(32'(state), 32'(LPMC_ST_NORMAL));
		chk(32'(ctrl), 32'h7a);
		reg_chk(LPMC_ADDR_STANDBY_CTRL, 32'h0);
		reg_chk(LPMC_ADDR_WARMUP, 32'h300);
		reg_chk(LPMC_ADDR_RESET_CAUSE, 32'h1);
		$display("pin reset test done");
	endtask : t_pin_rst
	initial begin
		rst_b = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_idle();
		t_bad();
		reg_wr(LPMC_ADDR_RESET_CAUSE, 32'hff);
		t_stop(8'h08, LPMC_ST_WARMUP);
		t_stop(8'h01, LPMC_ST_NORMAL);
		reg_chk(LPMC_ADDR_RESET_CAUSE, 32'h2);
		reg_wr(LPMC_ADDR_RESET_CAUSE, 32'hff);
		t_gated();
		t_pin_rst();
		print_verdict();
	end
endmodule : low_power_mode_controller_test
